// ---- src/ssb_stop_seq.sv ----
// Stop and brake sequencer for a thyristor motor starter with an APB register file.
//
// Functional notes
// - Stop begins by thyristor takeover, then method
// - Method codes one to five, reset coast
// - Torque ramps linear or square to end
// - End torque 0-100 percent, reset zero
// - Voltage steps down then ramps to minimum
// - Step-down level 0-100 percent, reset 100
// - Coast removes voltage at once
// - Brake method vector or reverse, reset vector
// - Vector brake above threshold, DC below
// - Run relay on when running, reverse for brake
// - Reverse brake above threshold, DC below
// - Reverse relay held off for braking delay
// - DC brake drives phases two and three
// - DC ends on standstill, timeout or sensor
// - Stop time bounds every non-coast method after takeover
// - Vector strength 0-100 percent, reset 75
// - DC strength 0-100 percent, reset 15
// - DC switch-over speed, reset 30 percent
// - Active jog asserts run command
`timescale 1ns/1ps
`include "ssb_map.svh"

module ssb_stop_seq #(
    parameter int STEP_CYC = `SSB_CLK_HZ / 1000 * `SSB_TICK_MS / `SSB_RAMP_STEPS
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        run_req,
    input  wire logic        jog_forward_input,
    input  wire logic        jog_reverse_input,
    input  wire logic        thyr_current_ok,
    input  wire logic        ext_standstill,
    input  wire logic [6:0]  speed_pct,
    input  wire logic [7:0]  torque_pct,
    output logic             run_cmd,
    output logic             bypass_open,
    output logic             thyr_fire,
    output logic      [2:0]  fire_phase,
    output logic      [7:0]  torque_ref,
    output logic      [6:0]  volt_ref,
    output logic      [6:0]  brake_pwr,
    output logic             run_contactor_relay,
    output logic             reverse_contactor_relay,
    output logic             stop_timeout
);
    import ssb_pkg::*;

    // Configuration registers.
    logic [2:0]  meth_q;       // Stop method selector.
    logic        bmeth_q;      // Brake method, one selects phase reversal.
    logic        extss_q;      // External standstill sensor enable.
    logic [10:0] stopt_q;      // Stop time in 100 ms units.
    logic [10:0] bdly_q;       // Reverse braking delay in 100 ms units.
    logic [6:0]  endtq_q;      // End torque in percent.
    logic [6:0]  stepv_q;      // Step-down voltage in percent.
    logic [6:0]  vstr_q;       // Vector braking strength.
    logic [6:0]  dstr_q;       // DC braking strength.
    logic [6:0]  dcspd_q;      // DC switch-over speed.
    // Sequencer state and timers.
    ssb_state_t  state_q;      // Current state.
    ssb_state_t  state_d;      // Next state.
    logic [23:0] step_cnt_q;   // Divider for ramp steps.
    logic        step_en;      // One pulse per ramp step.
    logic [7:0]  sub8_q;       // Steps within one 100 ms tick.
    logic        tick_en;      // One pulse per 100 ms.
    logic [10:0] sub_q;        // Steps within one ramp fraction.
    logic [8:0]  frac_q;       // Remaining fraction of stop time, of 256.
    logic [10:0] gap_q;        // Ticks elapsed in the relay gap.
    logic [7:0]  tq_start_q;   // Torque captured at stop onset.
    logic        timeout;      // Stop time has run out.
    logic        ramping;      // A timed stop method is running.
    // Synchronisers for pins.
    logic [3:0]  pin_m_q;      // First flop stage.
    logic [3:0]  pin_s_q;      // Second flop stage.
    logic        cur_ok_s;     // Thyristor current confirmed.
    logic        ext_ss_s;     // External standstill.
    logic        jog_active;   // Jog command present.
    logic        fast;         // Speed above switch-over threshold.
    logic        standstill;   // Motor stopped.
    // APB decode.
    logic        wr_en;        // Write in access phase.
    logic        mapped;       // Address hits a register.

    // Two flip-flop synchroniser for all asynchronous pins.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pin_m_q <= 4'h0;
            pin_s_q <= 4'h0;
        end
        else
        begin
            pin_m_q <= {jog_reverse_input, jog_forward_input, ext_standstill, thyr_current_ok};
            pin_s_q <= pin_m_q;
        end
    end

    assign cur_ok_s   = pin_s_q[0];
    assign ext_ss_s   = pin_s_q[1];
    assign fast       = speed_pct > dcspd_q;
    assign standstill = (speed_pct == 7'h00) || (extss_q && ext_ss_s);
    assign jog_active = pin_s_q[2] || pin_s_q[3];

    // jog forces run
    // A jog direction outside the permitted set is filtered upstream.
    assign run_cmd = run_req || jog_active;

    // APB slave: zero wait states, error on unmapped addresses.
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign mapped  = (paddr <= `SSB_STAT_OFS) && (paddr[1:0] == 2'h0);
    assign pslverr = psel && penable && !mapped;

    // Register writes; out of range times and levels saturate.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            meth_q  <= `SSB_METH_RST;
            bmeth_q <= 1'b0;
            extss_q <= 1'b0;
            stopt_q <= `SSB_STOPT_RST;
            bdly_q  <= `SSB_BDLY_RST;
            endtq_q <= `SSB_ENDTQ_RST;
            stepv_q <= `SSB_STEPV_RST;
            vstr_q  <= `SSB_VSTR_RST;
            dstr_q  <= `SSB_DSTR_RST;
            dcspd_q <= `SSB_DCSPD_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                `SSB_CTRL_OFS:
                begin
                    // Codes outside one to five are ignored.
                    if (pwdata[2:0] >= 3'h1 && pwdata[2:0] <= 3'h5)
                    begin
                        meth_q <= pwdata[`SSB_METH_LSB +: 3];
                    end
                    bmeth_q <= pwdata[`SSB_BMETH_BIT];
                    extss_q <= pwdata[`SSB_EXTSS_BIT];
                end
                `SSB_STOPT_OFS: stopt_q <= sat_t(pwdata[15:0]);
                `SSB_BDLY_OFS:  bdly_q  <= sat_t(pwdata[15:0]);
                `SSB_LEVEL_OFS:
                begin
                    endtq_q <= sat_p(pwdata[`SSB_ENDTQ_LSB +: 7]);
                    stepv_q <= sat_p(pwdata[`SSB_STEPV_LSB +: 7]);
                end
                `SSB_BRAKE_OFS:
                begin
                    vstr_q  <= sat_p(pwdata[`SSB_VSTR_LSB +: 7]);
                    dstr_q  <= sat_p(pwdata[`SSB_DSTR_LSB +: 7]);
                    dcspd_q <= sat_p(pwdata[`SSB_DCSPD_LSB +: 7]);
                end
                default: ;
            endcase
        end
    end

    // Clamp a time to 120 s.
    function automatic logic [10:0] sat_t(input logic [15:0] v);
        sat_t = (v > {5'h00, `SSB_TIME_MAX}) ? `SSB_TIME_MAX : v[10:0];
    endfunction

    // Clamp a percentage to 100.
    function automatic logic [6:0] sat_p(input logic [6:0] v);
        sat_p = (v > 7'h64) ? 7'h64 : v;
    endfunction

    // Read multiplexer; the status word shows the sequencer state.
    always_comb
    begin
        prdata = 32'h0000_0000;
        case (paddr)
            `SSB_CTRL_OFS:  prdata = {26'h0, extss_q, bmeth_q, 1'b0, meth_q};
            `SSB_STOPT_OFS: prdata = {21'h0, stopt_q};
            `SSB_BDLY_OFS:  prdata = {21'h0, bdly_q};
            `SSB_LEVEL_OFS: prdata = {17'h0, stepv_q, 1'b0, endtq_q};
            `SSB_BRAKE_OFS: prdata = {9'h0, dcspd_q, 1'b0, dstr_q, 1'b0, vstr_q};
            `SSB_STAT_OFS:  prdata = {21'h0, stop_timeout, reverse_contactor_relay,
                                      run_contactor_relay, thyr_fire, 3'h0, state_q};
            default:        prdata = 32'h0000_0000;
        endcase
    end

    // Ramp step and 100 ms tick dividers.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            step_cnt_q <= 24'h00_0000;
            sub8_q     <= 8'h00;
        end
        else if (step_en)
        begin
            step_cnt_q <= 24'h00_0000;
            sub8_q     <= sub8_q + 8'h01;
        end
        else
        begin
            step_cnt_q <= step_cnt_q + 24'h00_0001;
        end
    end

    assign step_en = (step_cnt_q == 24'(STEP_CYC - 1));
    assign tick_en = step_en && (sub8_q == 8'hFF);
    assign ramping = (state_q != ST_IDLE) && (state_q != ST_RUN) &&
                     (state_q != ST_HANDOVER) && (state_q != ST_COAST);
    assign timeout = ramping && (frac_q == 9'h000);

    // Stop time fraction: falls from 256 to 0 across the stop time.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            frac_q <= 9'h000;
            sub_q  <= 11'h000;
        end
        else if (state_q == ST_HANDOVER)
        begin
            frac_q <= (stopt_q == 11'h000) ? 9'h000 : 9'h100;
            sub_q  <= 11'h000;
        end
        else if (ramping && step_en && frac_q != 9'h000)
        begin
            if (sub_q + 11'h001 >= stopt_q)
            begin
                sub_q  <= 11'h000;
                frac_q <= frac_q - 9'h001;
            end
            else
            begin
                sub_q <= sub_q + 11'h001;
            end
        end
    end

    // Relay gap timer and capture of onset torque.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            gap_q      <= 11'h000;
            tq_start_q <= 8'h00;
        end
        else
        begin
            if (state_q != ST_REVGAP)
            begin
                gap_q <= 11'h000;
            end
            // Count one tick past the delay, since the free running tick may come early.
            else if (tick_en && gap_q <= bdly_q)
            begin
                gap_q <= gap_q + 11'h001;
            end
            if (state_q == ST_RUN)
            begin
                tq_start_q <= torque_pct;
            end
        end
    end

    // Next state.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (run_cmd)
                begin
                    state_d = ST_RUN;
                end
            ST_RUN:
                if (!run_cmd)
                begin
                    state_d = ST_HANDOVER;
                end
            ST_HANDOVER:
                if (meth_q == METH_COAST)
                begin
                    state_d = ST_COAST;
                end
                else if (cur_ok_s)
                begin
                    case (meth_q)
                        METH_LIN_TORQ, METH_SQR_TORQ: state_d = ST_TORQ;
                        METH_VOLT:                    state_d = ST_VOLT;
                        default: state_d = bmeth_q ? ST_REVGAP : ST_VECT;
                    endcase
                end
            ST_COAST: state_d = ST_IDLE;
            ST_VECT:
                if (!fast)
                begin
                    state_d = ST_DC;
                end
            ST_REVGAP:
                if (gap_q > bdly_q)
                begin
                    state_d = ST_REV;
                end
            ST_REV:
                if (!fast)
                begin
                    state_d = ST_DC;
                end
            ST_DC:
                if (standstill)
                begin
                    state_d = ST_IDLE;
                end
            default: state_d = state_q;
        endcase
        if (timeout)
        begin
            state_d = ST_IDLE;
        end
    end

    // State register.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Ramp arithmetic, linear and square fractions of the span.
    logic [8:0]  frac2;        // Square law fraction.
    logic [7:0]  tq_span;      // Onset minus end torque.
    logic [17:0] tq_prod;      // Span times fraction.
    logic [6:0]  v_span;       // Step-down minus minimum.
    logic [15:0] v_prod;       // Voltage span times fraction.
    logic [17:0] fsq;          // Fraction squared.
    always_comb
    begin
        fsq     = 18'(frac_q * frac_q);
        frac2   = fsq[16:8];
        tq_span = (tq_start_q > {1'b0, endtq_q}) ? tq_start_q - {1'b0, endtq_q} : 8'h00;
        tq_prod = 18'(tq_span * ((meth_q == METH_SQR_TORQ) ? frac2 : frac_q));
        v_span  = (stepv_q > `SSB_VMIN_PCT) ? stepv_q - `SSB_VMIN_PCT : 7'h00;
        v_prod  = 16'(v_span * frac_q);
    end

    // Registered power stage and relay outputs, aligned with state_q.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bypass_open             <= 1'b1;
            thyr_fire               <= 1'b0;
            fire_phase              <= 3'h0;
            torque_ref              <= 8'h00;
            volt_ref                <= 7'h00;
            brake_pwr               <= 7'h00;
            run_contactor_relay     <= 1'b0;
            reverse_contactor_relay <= 1'b0;
        end
        else
        begin
            bypass_open <= (state_d != ST_RUN);
            thyr_fire   <= (state_d != ST_IDLE) && (state_d != ST_RUN) && (state_d != ST_COAST);
            fire_phase  <= 3'h7;
            // run relay during run and handover
            run_contactor_relay     <= (state_d == ST_RUN) || (state_d == ST_HANDOVER);
            reverse_contactor_relay <= (state_d == ST_REV);
            torque_ref <= 8'h00;
            volt_ref   <= 7'h00;
            brake_pwr  <= 7'h00;
            case (state_d)
                ST_TORQ: torque_ref <= {1'b0, endtq_q} + tq_prod[15:8];
                ST_VOLT: volt_ref <= `SSB_VMIN_PCT + v_prod[14:8];
                ST_VECT, ST_REV: brake_pwr <= vstr_q;
                // DC on phases two and three
                ST_DC:
                begin
                    fire_phase <= 3'h6;
                    brake_pwr  <= dstr_q;
                end
                ST_IDLE, ST_RUN, ST_COAST, ST_REVGAP: fire_phase <= 3'h0;
                default: ;
            endcase
        end
    end

    // Sticky timeout indication, cleared when a new run begins.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            stop_timeout <= 1'b0;
        end
        else if (timeout)
        begin
            stop_timeout <= 1'b1;
        end
        else if (state_q == ST_RUN)
        begin
            stop_timeout <= 1'b0;
        end
    end

    // Handover leaves for a timed method only with current confirmed.
    sequence s_handover_done;
        state_q == ST_HANDOVER ##1 state_q inside {ST_TORQ, ST_VOLT, ST_VECT, ST_REVGAP};
    endsequence

    a_method_after_current: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_handover_done |-> $past(cur_ok_s))
        else $error("Stop method began before thyristor current.");

    a_method_reset_coast: assert property (@(posedge clk_sys)
        !rst_n |=> meth_q == METH_COAST && bmeth_q == 1'b0)
        else $error("Selectors did not reset to coast and vector.");

    a_coast_no_fire: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == ST_COAST |-> !thyr_fire && fire_phase == 3'h0)
        else $error("Thyristors fired during coast.");

    a_vector_to_dc: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == ST_VECT && !fast && !timeout |=> state_q == ST_DC)
        else $error("Vector brake did not switch to DC.");

    a_relays_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(run_contactor_relay && reverse_contactor_relay))
        else $error("Both contactor relays energised.");

    a_reverse_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(reverse_contactor_relay) |-> $past(gap_q) > bdly_q)
        else $error("Reverse relay energised before braking delay.");

    a_dc_phases: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == ST_DC |-> fire_phase == 3'h6 && brake_pwr == dstr_q)
        else $error("DC brake drove the wrong phases.");

    a_timeout_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
        timeout |=> state_q == ST_IDLE && !thyr_fire && !reverse_contactor_relay ##1 stop_timeout)
        else $error("Timeout did not end the stop.");

    a_jog_runs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        jog_active && state_q == ST_IDLE |=> state_q == ST_RUN)
        else $error("Jog active without run command.");

endmodule // ssb_stop_seq

// ---- src/ssb_map.svh ----
// Register offsets, field positions, reset values and timing counts of the stop sequencer.
`ifndef SSB_MAP_SVH
`define SSB_MAP_SVH
// Register byte offsets.
`define SSB_CTRL_OFS     12'h000
`define SSB_STOPT_OFS    12'h004
`define SSB_BDLY_OFS     12'h008
`define SSB_LEVEL_OFS    12'h00C
`define SSB_BRAKE_OFS    12'h010
`define SSB_STAT_OFS     12'h014
// Control fields.
`define SSB_METH_LSB     0
`define SSB_BMETH_BIT    4
`define SSB_EXTSS_BIT    5
// Level and brake field positions.
`define SSB_ENDTQ_LSB    0
`define SSB_STEPV_LSB    8
`define SSB_VSTR_LSB     0
`define SSB_DSTR_LSB     8
`define SSB_DCSPD_LSB    16
// Reset values (times in 100 ms units, levels in percent).
`define SSB_METH_RST     3'h4
`define SSB_STOPT_RST    11'h064
`define SSB_BDLY_RST     11'h005
`define SSB_ENDTQ_RST    7'h00
`define SSB_STEPV_RST    7'h64
`define SSB_VSTR_RST     7'h4B
`define SSB_DSTR_RST     7'h0F
`define SSB_DCSPD_RST    7'h1E
`define SSB_TIME_MAX     11'h4B0
// Timing: clock rate, time unit and ramp resolution.
`define SSB_CLK_HZ       125000000
`define SSB_TICK_MS      100
`define SSB_RAMP_STEPS   256
`define SSB_VMIN_PCT     7'h0A
`endif

// ---- src/ssb_pkg.sv ----
// Types shared by the stop sequencer.
package ssb_pkg;
    // Sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE, ST_RUN, ST_HANDOVER, ST_TORQ, ST_VOLT, ST_COAST,
        ST_VECT, ST_REVGAP, ST_REV, ST_DC
    } ssb_state_t;
    // Stop method selector codes.
    typedef enum logic [2:0] {
        METH_LIN_TORQ = 3'h1, METH_SQR_TORQ = 3'h2, METH_VOLT = 3'h3,
        METH_COAST = 3'h4, METH_BRAKE = 3'h5
    } ssb_meth_t;
endpackage

// ---- sim/ssb_power_model.sv ----
// Behavioural model of the thyristor stage, bypass, run contactor and motor.
`timescale 1ns/1ps

module ssb_power_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       thyr_fire,
    input  wire logic       run_contactor_relay,
    input  wire logic [7:0] lag,
    output logic            thyr_current_ok,
    output logic      [6:0] speed_pct,
    output logic      [7:0] torque_pct
);
    logic [7:0] fire_cnt_q;  // Cycles since firing began.
    logic [4:0] div_q;       // Slows the spin-down.

    // Current builds up only after the set lag of firing.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !thyr_fire)
        begin
            fire_cnt_q <= 8'h00;
        end
        else if (fire_cnt_q != 8'hFF)
        begin
            fire_cnt_q <= fire_cnt_q + 8'h01;
        end
    end
    assign thyr_current_ok = thyr_fire && (fire_cnt_q >= lag);

    // The motor runs at full speed on the bypass and slows down once the run contactor drops.
    // The divider is reset as well, so that the spin-down never stalls on an unknown count.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            div_q     <= 5'h00;
            speed_pct <= 7'h00;
        end
        else
        begin
            div_q <= div_q + 5'h01;
            if (run_contactor_relay && !thyr_fire)
            begin
                speed_pct <= 7'h64;
            end
            else if (div_q == 5'h1F && speed_pct != 7'h00 && !run_contactor_relay)
            begin
                speed_pct <= speed_pct - 7'h01;
            end
        end
    end
    assign torque_pct = {1'b0, speed_pct};
endmodule // ssb_power_model

// ---- sim/tb_top.sv ----
// Self-checking testbench of the stop sequencer.
`timescale 1ns/1ps
`include "ssb_map.svh"

module tb_top;
    logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, run_req = 0, jog_forward_input = 0, jog_reverse_input = 0;
    logic        thyr_current_ok, ext_standstill = 0, run_cmd, bypass_open, thyr_fire;
    logic [6:0]  speed_pct, volt_ref, brake_pwr;
    logic [7:0]  torque_pct, torque_ref, lag = 8'h02;
    logic [2:0]  fire_phase;
    logic        run_contactor_relay, reverse_contactor_relay, stop_timeout, err_q;
    int          error_cnt = 0, checked = 0;

    always #4 clk_sys = ~clk_sys;

    ssb_stop_seq #(.STEP_CYC(4)) u_ssb_stop_seq (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_req(run_req), .jog_forward_input(jog_forward_input),
        .jog_reverse_input(jog_reverse_input), .thyr_current_ok(thyr_current_ok),
        .ext_standstill(ext_standstill), .speed_pct(speed_pct), .torque_pct(torque_pct),
        .run_cmd(run_cmd), .bypass_open(bypass_open), .thyr_fire(thyr_fire), .fire_phase(fire_phase),
        .torque_ref(torque_ref), .volt_ref(volt_ref), .brake_pwr(brake_pwr),
        .run_contactor_relay(run_contactor_relay), .reverse_contactor_relay(reverse_contactor_relay),
        .stop_timeout(stop_timeout));

    ssb_power_model u_ssb_power_model (.clk_sys(clk_sys), .rst_n(rst_n), .thyr_fire(thyr_fire),
        .run_contactor_relay(run_contactor_relay), .lag(lag), .thyr_current_ok(thyr_current_ok),
        .speed_pct(speed_pct), .torque_pct(torque_pct));

    // Prints the verdict and ends the run.
    task automatic stop_test;
        if (error_cnt == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Compares one value and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            chk("pready", 1, 0);
            stop_test;
        end
    endtask

    // Polls the state field until it shows the given state.
    task automatic wait_st(input logic [3:0] s);
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `SSB_STAT_OFS, 32'h0, q);
            n++;
        end
        while (q[3:0] !== s && n < 12000);
        chk("state", {28'h0, s}, {28'h0, q[3:0]});
        if (q[3:0] !== s)
            stop_test;
    endtask

    // Runs the motor on the bypass, then withdraws the run request.
    task automatic go_stop;
        run_req <= 1'b1;
        wait_st(4'h1);
        repeat (20) @(posedge clk_sys);
        chk("run relay", 1, run_contactor_relay);
        chk("bypass_open", 0, bypass_open);
        run_req <= 1'b0;
    endtask

    // Reset values of every setting and a refused unmapped read.
    task automatic t_regs;
        logic [11:0] a[5] = '{`SSB_CTRL_OFS, `SSB_STOPT_OFS, `SSB_BDLY_OFS, `SSB_LEVEL_OFS, `SSB_BRAKE_OFS};
        logic [31:0] e[5] = '{32'h0000_0004, 32'h0000_0064, 32'h0000_0005, 32'h0000_6400, 32'h001E_0F4B};
        logic [31:0] m[5] = '{32'h0000_0037, 32'h0000_07FF, 32'h0000_07FF, 32'h0000_7F7F, 32'h007F_7F7F};
        logic [31:0] q;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, a[i], 32'h0, q);
            chk("reset value", e[i], q & m[i]);
        end
        apb(1'b0, 12'h018, 32'h0, q);
        chk("unmapped pslverr", 1, err_q);
    endtask

    // Jog alone runs the motor; the reset method coasts it to a stop.
    task automatic t_jog;
        // Forward jog is wired and permitted.
        jog_forward_input <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("run_cmd", 1, run_cmd);
        wait_st(4'h1);
        jog_forward_input <= 1'b0;
        wait_st(4'h0);
        chk("coast fire", 0, {thyr_fire, fire_phase, volt_ref});
        chk("coast timeout", 0, stop_timeout);
    endtask

    // Torque and voltage stops wait for current, ramp within bounds and end by timeout.
    task automatic t_ramp(input logic [2:0] m);
        logic [31:0] q;
        logic [7:0] v;
        apb(1'b1, `SSB_STOPT_OFS, 32'h2, q);
        apb(1'b1, `SSB_LEVEL_OFS, 32'h0000_3C14, q);
        apb(1'b1, `SSB_CTRL_OFS, {29'h0, m}, q);
        lag <= 8'd60;
        go_stop;
        repeat (8) @(posedge clk_sys);
        chk("handover fire", 32'h0F, {torque_ref[0], thyr_fire, fire_phase});
        wait_st(4'h2);
        wait_st(m == 3'h3 ? 4'h4 : 4'h3);
        v = (m == 3'h3) ? {1'b0, volt_ref} : torque_ref;
        chk("ramp level", 1, (m == 3'h3) ? (v >= 10 && v <= 60) : (v >= 20 && v <= 100));
        wait_st(4'h0);
        chk("timeout end", 32'h8, {stop_timeout, thyr_fire, run_contactor_relay, reverse_contactor_relay});
    endtask

    // Vector or reverse braking, then DC braking to standstill or sensor.
    task automatic t_brake(input logic bm);
        logic [31:0] q;
        apb(1'b1, `SSB_STOPT_OFS, 32'd20, q);
        apb(1'b1, `SSB_BDLY_OFS, 32'd1, q);
        apb(1'b1, `SSB_CTRL_OFS, {26'h0, !bm, bm, 1'b0, 3'h5}, q);
        lag <= 8'd2;
        go_stop;
        if (bm)
        begin
            wait_st(4'h7);
            chk("gap relays", 0, {run_contactor_relay, reverse_contactor_relay});
            wait_st(4'h8);
            chk("reverse relay", 1, reverse_contactor_relay);
        end
        else
        begin
            wait_st(4'h6);
            chk("vector power", 75, brake_pwr);
        end
        wait_st(4'h9);
        chk("dc phases", 32'h30F, {fire_phase, brake_pwr});
        chk("dc speed", 1, speed_pct <= 30);
        ext_standstill <= !bm;
        wait_st(4'h0);
        chk("dc end", {31'h0, bm}, {stop_timeout, speed_pct == 0});
        ext_standstill <= 1'b0;
    endtask

    // Main sequence.
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs;
        t_jog;
        for (int m = 1; m <= 3; m++)
            t_ramp(m[2:0]);
        t_brake(1'b0);
        t_brake(1'b1);
        stop_test;
    end
endmodule // tb_top
